// File: test/mroro_monitor.sv
// Checker for the OR, return and rotate execution unit
`timescale 1ns/100ps
module mroro_monitor
	import mroro_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH
) (
	input wire logic                         clk,
	input wire logic                         resetn,
	input wire logic                         instr_valid,
	input wire mroro_instr_t                 instr,
	input wire logic                         irq_pending,
	input wire logic [ADDR_W-1:0]            dbg_addr,
	input wire mroro_state_t                 state,
	input wire logic                         instr_done,
	input wire logic                         irq_entry,
	input wire logic [DATA_W-1:0]            dbg_data,
	input wire logic [$clog2(DEPTH+1)-1:0]   stack_level
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_nop_holds: assert property (instr_done && $past(instr.op) == OP_NOP |->
		$stable(state.accumulator) && $stable(state.zero) && $stable(stack_level))
		else $error("no-operation changed state");
	chk_nop_pc: assert property (instr_done && $past(instr.op) == OP_NOP |->
		state.pc == $past(state.pc) + PC_STEP)
		else $error("no-operation did not advance counter");
	chk_entry_vector: assert property (irq_entry |-> state.pc == IRQ_VECTOR
		&& !state.master_interrupt_enable)
		else $error("interrupt entry state wrong");
	chk_or_imm_acc: assert property (instr_done && $past(instr.op) == OP_OR_A_IMM |->
		state.accumulator == ($past(state.accumulator) | $past(instr.imm)))
		else $error("OR immediate result wrong");
	chk_or_mem_acc: assert property (instr_done && $past(instr.op) == OP_OR_A_MEM |->
		(state.accumulator & $past(state.accumulator)) == $past(state.accumulator))
		else $error("OR memory lost accumulator bits");
	chk_zero_flag: assert property (instr_done && $past(instr.op) inside {OP_OR_A_IMM,
		OP_OR_A_MEM} |-> state.zero == (state.accumulator == ZERO_BYTE))
		else $error("zero flag wrong");
	chk_orm_keeps_acc: assert property (instr_done && $past(instr.op) == OP_OR_MEM |->
		$stable(state.accumulator) && (!state.zero || $past(state.accumulator) == ZERO_BYTE))
		else $error("OR to memory touched accumulator or zero");
	chk_ret_flags: assert property (instr_done && $past(instr.op) inside {OP_RET, OP_RET_IMM,
		OP_INTERRUPT_RETURN_INSTR, OP_RL} |-> $stable(state.zero))
		else $error("return or rotate changed zero flag");
	chk_ret_imm_acc: assert property (instr_done && $past(instr.op) == OP_RET_IMM |->
		state.accumulator == $past(instr.imm))
		else $error("return immediate accumulator wrong");
	chk_interrupt_return_instr_enable: assert property (instr_done && $past(instr.op) == OP_INTERRUPT_RETURN_INSTR |->
		state.master_interrupt_enable == 1'b1)
		else $error("interrupt return left enable clear");
	chk_ret_pop: assert property (instr_done && $past(instr.op) inside {OP_RET, OP_RET_IMM,
		OP_INTERRUPT_RETURN_INSTR} && $past(stack_level) != 0 |-> stack_level == $past(stack_level) - 1)
		else $error("return did not pop one entry");
	chk_irq_after_interrupt_return_instr: assert property (instr_done && $past(instr.op) == OP_INTERRUPT_RETURN_INSTR
		&& irq_pending && $past(irq_pending, 4) |-> ##[1:3] irq_entry)
		else $error("pending interrupt not taken after return");
endmodule

bind mroro_core mroro_monitor #(.DEPTH(DEPTH)) mroro_monitor_i (.clk(clk), .resetn(resetn),
	.instr_valid(instr_valid), .instr(instr), .irq_pending(irq_pending), .dbg_addr(dbg_addr),
	.state(state), .instr_done(instr_done), .irq_entry(irq_entry), .dbg_data(dbg_data),
	.stack_level(stack_level));

// File: test/tb.sv
// Self-checking bench for the OR, return and rotate execution unit
`timescale 1ns/100ps
module tb;
	import mroro_pkg::*;
	logic         clk             = 1'b0;
	logic         resetn          = 1'b0;
	logic         instr_valid     = 1'b0;
	mroro_instr_t instr           = '0;
	logic         irq_pending     = 1'b0;
	logic [7:0]   dbg_addr        = 8'h10;
	mroro_state_t state;
	logic         instr_done;
	logic         irq_entry;
	logic [7:0]   dbg_data;
	logic [3:0]   stack_level;
	logic [11:0]  ret_pc;
	int           err_total       = 0;
	int           samples_checked = 0;

	always #5 clk = ~clk;

	mroro_core mroro_core_i (.clk(clk), .resetn(resetn), .instr_valid(instr_valid),
		.instr(instr), .irq_pending(irq_pending), .dbg_addr(dbg_addr), .state(state),
		.instr_done(instr_done), .irq_entry(irq_entry), .dbg_data(dbg_data),
		.stack_level(stack_level));

	task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_w(input logic [11:0] got, input logic [11:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk_f(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic exec(input mroro_op_t op, input logic [7:0] imm, input logic [11:0] tgt);
		int i;
		i = 0;
		step(1);
		instr_valid = 1'b1;
		instr = '{op, 8'h10, imm, tgt};
		do begin
			step(1);
			i++;
		end while (instr_done !== 1'b1 && i < 10);
		instr_valid = 1'b0;
		chk_f(instr_done, 1'b1);
	endtask

	task automatic t_or_imm();
		exec(OP_NOP, 8'h00, 12'h000);
		chk_w(state.pc, 12'h001);
		exec(OP_OR_A_IMM, 8'h00, 12'h000);
		chk_f(state.zero, 1'b1);
		exec(OP_OR_A_IMM, 8'h5a, 12'h000);
		chk_b(state.accumulator, 8'h5a);
		chk_f(state.zero, 1'b0);
		$display("test or_imm done");
	endtask

	task automatic t_mem();
		exec(OP_RET_IMM, 8'h81, 12'h000);
		exec(OP_OR_MEM, 8'h00, 12'h000);
		chk_f(state.zero, 1'b0);
		exec(OP_RL, 8'h00, 12'h000);
		step(1);
		chk_b(dbg_data & 8'h03, 8'h03);
		chk_f(state.zero, 1'b0);
		chk_b(state.accumulator, 8'h81);
		exec(OP_OR_A_IMM, 8'hff, 12'h000);
		exec(OP_OR_MEM, 8'h00, 12'h000);
		step(1);
		chk_b(dbg_data, 8'hff);
		chk_b(state.accumulator, 8'hff);
		exec(OP_RET_IMM, 8'h00, 12'h000);
		exec(OP_OR_A_IMM, 8'h00, 12'h000);
		exec(OP_RL, 8'h00, 12'h000);
		step(1);
		chk_b(dbg_data, 8'hff);
		chk_f(state.zero, 1'b1);
		exec(OP_OR_A_MEM, 8'h00, 12'h000);
		chk_b(state.accumulator, 8'hff);
		chk_f(state.zero, 1'b0);
		step(1);
		chk_b(dbg_data, 8'hff);
		$display("test memory done");
	endtask

	task automatic t_ret();
		ret_pc = state.pc + 12'h001;
		exec(OP_CALL, 8'h00, 12'h123);
		chk_b({4'h0, stack_level}, 8'h01);
		exec(OP_RET_IMM, 8'h00, 12'h000);
		chk_w(state.pc, ret_pc);
		chk_b(state.accumulator, 8'h00);
		chk_f(state.zero, 1'b0);
		ret_pc = state.pc + 12'h001;
		exec(OP_CALL, 8'h00, 12'h345);
		exec(OP_OR_A_IMM, 8'h00, 12'h000);
		exec(OP_RET, 8'h00, 12'h000);
		chk_w(state.pc, ret_pc);
		chk_f(state.zero, 1'b1);
		chk_b({4'h0, stack_level}, 8'h00);
		$display("test return done");
	endtask

	task automatic t_interrupt_return_instr();
		int i;
		ret_pc = state.pc + 12'h001;
		exec(OP_CALL, 8'h00, 12'h200);
		irq_pending = 1'b1;
		step(6);
		chk_f(state.master_interrupt_enable, 1'b0);
		exec(OP_INTERRUPT_RETURN_INSTR, 8'h00, 12'h000);
		chk_w(state.pc, ret_pc);
		chk_f(state.master_interrupt_enable, 1'b1);
		for (i = 0; i < 10 && irq_entry !== 1'b1; i++) step(1);
		chk_f(irq_entry, 1'b1);
		chk_w(state.pc, IRQ_VECTOR);
		chk_b({4'h0, stack_level}, 8'h01);
		irq_pending = 1'b0;
		step(6);
		exec(OP_INTERRUPT_RETURN_INSTR, 8'h00, 12'h000);
		chk_w(state.pc, ret_pc);
		chk_b({4'h0, stack_level}, 8'h00);
		$display("test interrupt return done");
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		#20000;
		err_total++;
		print_verdict();
	end

	initial begin
		step(3);
		resetn = 1'b1;
		t_or_imm();
		t_mem();
		t_ret();
		t_interrupt_return_instr();
		print_verdict();
	end
endmodule

// File: verilog/mroro_core.sv
// Execution unit for no-operation, OR, return and rotate-left instructions
// Summary of operation
// - No-operation changes nothing except advancing to the next instruction.
// - OR memory into accumulator: result to accumulator only, zero flag updated.
// - OR immediate into accumulator: result to accumulator, zero flag updated.
// - OR to memory: accumulator OR byte written back to memory, zero updated.
// - Subroutine return reloads program counter from stack top, flags unchanged.
// - Return with immediate reloads counter and loads accumulator with immediate.
// - Interrupt return restores counter and sets master interrupt enable to 1.
// - A pending interrupt is serviced right after interrupt return, before main code.
// - Rotate left moves memory byte left one, bit 7 into bit 0, no flags.
`timescale 1ns/100ps
module mroro_core
	import mroro_pkg::*;
#(
	parameter int                MEM_DEPTH = 1 << ADDR_W,
	parameter int                DEPTH     = STACK_DEPTH,
	parameter logic [PC_W-1:0]   VECTOR    = IRQ_VECTOR
) (
	input  wire logic                       clk,
	input  wire logic                       resetn,
	input  wire logic                       instr_valid,
	input  wire mroro_instr_t               instr,
	input  wire logic                       irq_pending,
	input  wire logic [ADDR_W-1:0]          dbg_addr,
	output mroro_state_t                    state,
	output logic                            instr_done,
	output logic                            irq_entry,
	output logic      [DATA_W-1:0]          dbg_data,
	output logic      [$clog2(DEPTH+1)-1:0] stack_level
);
	generate
		if (MEM_DEPTH < 1 || MEM_DEPTH > (1 << ADDR_W)) begin : g_chk
			$error("mroro_core: unsupported memory depth");
		end
	endgenerate

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [DATA_W-1:0] dmem [MEM_DEPTH];
	logic [PC_W-1:0]   pc_r;
	logic [PC_W-1:0]   pc_nxt;
	logic [DATA_W-1:0] acc_r;
	logic [DATA_W-1:0] acc_nxt;
	logic              zero_r;
	logic              zero_nxt;
	logic              mie_r;
	logic              mie_nxt;
	logic              busy_r;
	logic              busy_nxt;
	logic              done_r;
	logic              done_nxt;
	logic              entry_r;
	logic              entry_nxt;
	logic [DATA_W-1:0] dbg_r;
	logic [2:0]        irq_sync_r;
	logic              irq_lvl_r;
	logic              irq_lvl_nxt;
	logic              mem_we;
	logic [DATA_W-1:0] mem_wdata;
	logic [DATA_W-1:0] mem_rd;
	logic [DATA_W-1:0] or_res;
	logic              push;
	logic              pop;
	logic [PC_W-1:0]   push_data;
	logic [PC_W-1:0]   stack_top;
	logic              take_irq;
	logic              exec;

	mroro_stack #(
		.W     (PC_W),
		.DEPTH (DEPTH)
	) u_stack (
		.clk       (clk),
		.resetn    (resetn),
		.push      (push),
		.pop       (pop),
		.push_data (push_data),
		.top       (stack_top),
		.level     (stack_level)
	);

	// ------------------------------------------------------------
	// Interrupt request synchroniser
	// ------------------------------------------------------------
	always_comb begin
		irq_lvl_nxt = irq_lvl_r;
		if (irq_sync_r[1] == irq_sync_r[2]) begin
			irq_lvl_nxt = irq_sync_r[2];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_sync_r <= 3'h0;
			irq_lvl_r  <= 1'b0;
		end else begin
			irq_sync_r <= {irq_sync_r[1:0], irq_pending};
			irq_lvl_r  <= irq_lvl_nxt;
		end
	end

	// ------------------------------------------------------------
	// Execution
	// ------------------------------------------------------------
	always_comb begin
		mem_rd    = dmem[instr.addr];
		take_irq  = mie_r && irq_lvl_r && !busy_r;
		exec      = instr_valid && !busy_r && !take_irq;
		or_res    = acc_r | mem_rd;
		pc_nxt    = pc_r;
		acc_nxt   = acc_r;
		zero_nxt  = zero_r;
		mie_nxt   = mie_r;
		busy_nxt  = 1'b0;
		done_nxt  = 1'b0;
		entry_nxt = 1'b0;
		mem_we    = 1'b0;
		mem_wdata = mem_rd;
		push      = 1'b0;
		pop       = 1'b0;
		push_data = pc_r;
		if (take_irq) begin
			push      = 1'b1;
			pc_nxt    = VECTOR;
			mie_nxt   = 1'b0;
			busy_nxt  = 1'b1;
			entry_nxt = 1'b1;
		end else if (exec) begin
			busy_nxt = 1'b1;
			done_nxt = 1'b1;
			pc_nxt   = pc_r + PC_STEP;
			case (instr.op)
				OP_OR_A_MEM: begin
					acc_nxt  = or_res;
					zero_nxt = ~|or_res;
				end
				OP_OR_A_IMM: begin
					acc_nxt  = acc_r | instr.imm;
					zero_nxt = ~|(acc_r | instr.imm);
				end
				OP_OR_MEM: begin
					mem_we    = 1'b1;
					mem_wdata = or_res;
					zero_nxt  = ~|or_res;
				end
				OP_RET: begin
					pc_nxt = stack_top;
					pop    = 1'b1;
				end
				OP_RET_IMM: begin
					pc_nxt  = stack_top;
					acc_nxt = instr.imm;
					pop     = 1'b1;
				end
				OP_INTERRUPT_RETURN_INSTR: begin
					pc_nxt  = stack_top;
					mie_nxt = 1'b1;
					pop     = 1'b1;
				end
				OP_RL: begin
					mem_we    = 1'b1;
					mem_wdata = {mem_rd[MSB_POS-1:LSB_POS], mem_rd[MSB_POS]};
				end
				OP_CALL: begin
					push      = 1'b1;
					push_data = pc_r + PC_STEP;
					pc_nxt    = instr.target;
				end
				default: begin
					pc_nxt = pc_r + PC_STEP;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pc_r    <= PC_RESET;
			acc_r   <= ACC_RESET;
			zero_r  <= 1'b0;
			mie_r   <= MIE_RESET;
			busy_r  <= 1'b0;
			done_r  <= 1'b0;
			entry_r <= 1'b0;
			dbg_r   <= ZERO_BYTE;
		end else begin
			pc_r    <= pc_nxt;
			acc_r   <= acc_nxt;
			zero_r  <= zero_nxt;
			mie_r   <= mie_nxt;
			busy_r  <= busy_nxt;
			done_r  <= done_nxt;
			entry_r <= entry_nxt;
			dbg_r   <= dmem[dbg_addr];
		end
	end

	always_ff @(posedge clk) begin
		if (mem_we) begin
			dmem[instr.addr] <= mem_wdata;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign state.pc                      = pc_r;
	assign state.accumulator             = acc_r;
	assign state.zero                    = zero_r;
	assign state.master_interrupt_enable = mie_r;
	assign instr_done                    = done_r;
	assign irq_entry                     = entry_r;
	assign dbg_data                      = dbg_r;
endmodule

// File: verilog/mroro_pkg.sv
// Shared constants, opcodes and carriers for the OR, return and rotate execution unit
package mroro_pkg;
	// ------------------------------------------------------------
	// Widths and sizes
	// ------------------------------------------------------------
	localparam int DATA_W      = 8;
	localparam int ADDR_W      = 8;
	localparam int PC_W        = 12;
	localparam int STACK_DEPTH = 8;
	localparam int MSB_POS     = 7;
	localparam int LSB_POS     = 0;

	// ------------------------------------------------------------
	// Reset values and fixed addresses
	// ------------------------------------------------------------
	localparam logic [PC_W-1:0]   PC_RESET   = 12'h000;
	localparam logic [PC_W-1:0]   IRQ_VECTOR = 12'h004;
	localparam logic [PC_W-1:0]   PC_STEP    = 12'h001;
	localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
	localparam logic [DATA_W-1:0] ZERO_BYTE  = 8'h00;
	localparam logic              MIE_RESET  = 1'b0;

	// ------------------------------------------------------------
	// Operations
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NOP,
		OP_OR_A_MEM,
		OP_OR_A_IMM,
		OP_OR_MEM,
		OP_RET,
		OP_RET_IMM,
		OP_INTERRUPT_RETURN_INSTR,
		OP_RL,
		OP_CALL
	} mroro_op_t;

	typedef struct packed {
		mroro_op_t         op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] imm;
		logic [PC_W-1:0]   target;
	} mroro_instr_t;

	typedef struct packed {
		logic [PC_W-1:0]   pc;
		logic [DATA_W-1:0] accumulator;
		logic              zero;
		logic              master_interrupt_enable;
	} mroro_state_t;
endpackage

// File: verilog/mroro_stack.sv
// Hardware return-address stack
`timescale 1ns/100ps
module mroro_stack
	import mroro_pkg::*;
#(
	parameter int W     = PC_W,
	parameter int DEPTH = STACK_DEPTH
) (
	input  wire logic                       clk,
	input  wire logic                       resetn,
	input  wire logic                       push,
	input  wire logic                       pop,
	input  wire logic [W-1:0]               push_data,
	output logic      [W-1:0]               top,
	output logic      [$clog2(DEPTH+1)-1:0] level
);
	localparam int LW = $clog2(DEPTH + 1);
	localparam logic [LW-1:0] LVL_ONE  = LW'(1);
	localparam logic [LW-1:0] LVL_FULL = LW'(DEPTH);
	localparam logic [LW-1:0] LVL_NONE = '0;
	localparam int            IW       = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || W < 1) begin : g_chk
			$error("mroro_stack: unsupported depth or width");
		end
	endgenerate

	logic [W-1:0]  mem [DEPTH];
	logic [LW-1:0] level_r;
	logic [LW-1:0] level_nxt;
	logic          do_push;
	logic          do_pop;
	logic [LW-1:0] top_idx;

	// ------------------------------------------------------------
	// Pointer control
	// ------------------------------------------------------------
	always_comb begin
		do_push   = push && (level_r != LVL_FULL);
		do_pop    = pop && !push && (level_r != LVL_NONE);
		level_nxt = level_r;
		if (do_push) begin
			level_nxt = level_r + LVL_ONE;
		end else if (do_pop) begin
			level_nxt = level_r - LVL_ONE;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			level_r <= LVL_NONE;
		end else begin
			level_r <= level_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[level_r[IW-1:0]] <= push_data;
		end
	end

	// Top entry sits one below the fill level; an empty stack shows zero
	assign top_idx = level_r - LVL_ONE;
	assign top     = (level_r == LVL_NONE) ? '0 : mem[top_idx[IW-1:0]];
	assign level   = level_r;
endmodule
